// File: rtl/gled_top.sv
`timescale 1ns/1ps
// Overview of operation
// R1 - each pin independently push-pull output, open-drain output or input
// R2 - each pin selectable between general-purpose role and LED role
// R3 - LED role always drives open-drain
// R4 - speed indicator low at 100 Mb/s, during negotiation, cable unplugged
// R5 - speed indicator high only at 10 Mb/s
// R6 - link-activity indicator low while link valid and no pulse running
// R7 - activity on valid link drives link-activity high for 80 ms
// R8 - after off pulse, low for at least 80 ms
// R9 - after low interval, pulse again if activity was seen
// R10 - duplex indicator low in full duplex, high otherwise
// R11 - output role drives data bit; input level readable by software
// R12 - link down: link-activity high, running pulse abandoned
module gled_top #(
    parameter int FLASH_CYCLES = gled_pkg::FLASH_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic link_up,
    input wire logic link_10m,
    input wire logic autoneg_busy,
    input wire logic full_duplex,
    input wire logic tx_active,
    input wire logic rx_active,
    input wire logic [2:0] gpio_in,
    output logic [2:0] gpio_out,
    output logic [2:0] gpio_oe
);
    localparam int N = gled_pkg::PIN_COUNT;
    logic [N-1:0] dir_out;
    logic [N-1:0] open_drain;
    logic [N-1:0] led_role;
    logic [N-1:0] data;
    logic [N-1:0] pin_sync;
    logic [31:0] next_rdata;
    logic [N-1:0] next_dir_out;
    logic [N-1:0] next_open_drain;
    logic [N-1:0] next_led_role;
    logic [N-1:0] next_data;
    logic [N-1:0] led_n;
    logic [N-1:0] next_out;
    logic [N-1:0] next_oe;
    gled_act_if act ();

    // pin level per drive mode: open drain only ever pulls low
    function automatic logic [1:0] pin_drive(input logic level, input logic od);
        pin_drive = od ? {1'b0, ~level} : {level, 1'b1};
    endfunction

    assign act.link_up = link_up;
    assign act.activity = tx_active | rx_active;

    gled_activity #(
        .FLASH_CYCLES(FLASH_CYCLES)
    ) u_act (
        .mclk(mclk),
        .rst_n(rst_n),
        .act(act)
    );

    always_comb begin
        // unplugged cable counts as link down, so speed shows low
        led_n[0] = link_up & link_10m & ~autoneg_busy; // R4 R5
        led_n[1] = act.indicator_n; // R6
        led_n[2] = ~(link_up & full_duplex); // R10
    end

    always_comb begin
        next_dir_out = dir_out;
        next_open_drain = open_drain;
        next_led_role = led_role;
        next_data = data;
        next_rdata = 32'h0000_0000;
        if (reg_wr) begin
            unique case (reg_addr)
                gled_pkg::REG_CFG: begin
                    next_dir_out = reg_wdata[gled_pkg::CFG_DIR_LSB +: N]; // R1
                    next_open_drain = reg_wdata[gled_pkg::CFG_OD_LSB +: N]; // R1
                    next_led_role = reg_wdata[gled_pkg::CFG_LED_LSB +: N]; // R2
                end
                gled_pkg::REG_DATA: begin
                    next_data = reg_wdata[N-1:0]; // R11
                end
                default: begin
                end
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                gled_pkg::REG_CFG: begin
                    next_rdata[gled_pkg::CFG_DIR_LSB +: N] = dir_out;
                    next_rdata[gled_pkg::CFG_OD_LSB +: N] = open_drain;
                    next_rdata[gled_pkg::CFG_LED_LSB +: N] = led_role;
                end
                gled_pkg::REG_DATA: begin
                    next_rdata[N-1:0] = data;
                end
                gled_pkg::REG_STATUS: begin
                    next_rdata[N-1:0] = pin_sync; // R11
                end
                default: begin
                    next_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_comb begin
        for (int i = 0; i < N; i++) begin
            if (led_role[i]) begin
                {next_out[i], next_oe[i]} = pin_drive(led_n[i], 1'b1); // R3
            end else if (dir_out[i]) begin
                {next_out[i], next_oe[i]} = pin_drive(data[i], open_drain[i]); // R1 R11
            end else begin
                next_out[i] = 1'b0;
                next_oe[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dir_out <= gled_pkg::CFG_RESET[gled_pkg::CFG_DIR_LSB +: N];
            open_drain <= gled_pkg::CFG_RESET[gled_pkg::CFG_OD_LSB +: N];
            led_role <= gled_pkg::CFG_RESET[gled_pkg::CFG_LED_LSB +: N];
            data <= gled_pkg::DATA_RESET;
            reg_rdata <= 32'h0000_0000;
            pin_sync <= 3'h0;
            gpio_out <= 3'h0;
            gpio_oe <= 3'h0;
        end else begin
            dir_out <= next_dir_out;
            open_drain <= next_open_drain;
            led_role <= next_led_role;
            data <= next_data;
            reg_rdata <= next_rdata;
            pin_sync <= gpio_in;
            gpio_out <= next_out;
            gpio_oe <= next_oe;
        end
    end
endmodule

// File: rtl/gled_pkg.sv
package gled_pkg;
    localparam int PIN_COUNT = 3;
    localparam int CLK_HZ = 25000000;
    localparam int FLASH_MS = 80;
    localparam int FLASH_CYCLES = CLK_HZ / 1000 * FLASH_MS;
    localparam int FLASH_W = 22;
    // register offsets
    localparam logic [3:0] REG_CFG = 4'h0;
    localparam logic [3:0] REG_DATA = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    // config field positions: [2:0] dir out, [6:4] open drain, [10:8] led role
    localparam int CFG_DIR_LSB = 0;
    localparam int CFG_OD_LSB = 4;
    localparam int CFG_LED_LSB = 8;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [2:0] DATA_RESET = 3'h0;
    typedef enum logic [1:0] {
        GLED_IDLE = 2'b00,
        GLED_OFF = 2'b01,
        GLED_HOLD = 2'b11
    } gled_act_t;
endpackage

// File: rtl/gled_if.sv
`timescale 1ns/1ps
interface gled_act_if;
    logic link_up;
    logic activity;
    logic indicator_n;
    modport ctl (input link_up, input activity, output indicator_n);
    modport top (output link_up, output activity, input indicator_n);
endinterface

// File: rtl/gled_activity.sv
`timescale 1ns/1ps
module gled_activity #(
    parameter int FLASH_CYCLES = gled_pkg::FLASH_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_n,
    gled_act_if.ctl act
);
    localparam int W = gled_pkg::FLASH_W;
    // refused while elaborating, so a bad count never reaches a netlist
    if (FLASH_CYCLES < 1 || FLASH_CYCLES >= (1 << W)) begin : g_bad_count
        $error("flash count out of range");
    end
    gled_pkg::gled_act_t state;
    gled_pkg::gled_act_t next_state;
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic seen;
    logic next_seen;
    logic ind_n;
    logic next_ind_n;
    localparam logic [W-1:0] LAST = W'(FLASH_CYCLES - 1);

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_seen = seen;
        next_ind_n = ind_n;
        if (!act.link_up) begin
            next_state = gled_pkg::GLED_IDLE; // R12
            next_cnt = '0;
            next_seen = 1'b0;
            next_ind_n = 1'b1; // R12
        end else begin
            unique case (state)
                gled_pkg::GLED_IDLE: begin
                    next_ind_n = 1'b0; // R6
                    if (act.activity) begin
                        next_state = gled_pkg::GLED_OFF; // R7
                        next_ind_n = 1'b1;
                        next_cnt = '0;
                    end
                end
                gled_pkg::GLED_OFF: begin
                    next_cnt = cnt + 1'b1;
                    if (cnt == LAST) begin
                        next_state = gled_pkg::GLED_HOLD; // R8
                        next_ind_n = 1'b0;
                        next_cnt = '0;
                        next_seen = 1'b0;
                    end
                end
                gled_pkg::GLED_HOLD: begin
                    next_cnt = cnt + 1'b1;
                    // traffic during the hold is remembered, not dropped
                    if (act.activity) begin
                        next_seen = 1'b1;
                    end
                    if (cnt == LAST) begin
                        next_cnt = '0;
                        next_seen = 1'b0;
                        if (seen || act.activity) begin
                            next_state = gled_pkg::GLED_OFF; // R9
                            next_ind_n = 1'b1;
                        end else begin
                            next_state = gled_pkg::GLED_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= gled_pkg::GLED_IDLE;
            cnt <= '0;
            seen <= 1'b0;
            ind_n <= 1'b1;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            seen <= next_seen;
            ind_n <= next_ind_n;
        end
    end
    assign act.indicator_n = ind_n;
endmodule

// File: verification/gled_pads.sv
`timescale 1ns/1ps
module gled_pads (
    input wire logic [2:0] gpio_out,
    input wire logic [2:0] gpio_oe,
    input wire logic [2:0] ext_val,
    input wire logic [2:0] ext_en,
    output logic [2:0] gpio_in
);
    // board pull-ups: a pad nobody drives reads high, as an unlit led would
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            gpio_in[i] = gpio_oe[i] ? gpio_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
        end
    end
endmodule

// File: verification/gled_props.sv
`timescale 1ns/1ps
module gled_props #(
    parameter int FLASH_CYCLES = 10
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic link_up,
    input wire logic link_10m,
    input wire logic autoneg_busy,
    input wire logic full_duplex,
    input wire logic [2:0] gpio_out,
    input wire logic [2:0] gpio_oe
);
    logic [2:0] led_q;
    logic [2:0] led_d;
    logic slow;
    logic fdx;
    assign slow = link_up & link_10m & ~autoneg_busy;
    assign fdx = link_up & full_duplex;
    // shadow of the led role bits; pins lag them by a cycle
    always_ff @(posedge mclk) begin
        led_d <= rst_n ? led_q : 3'h0;
        if (!rst_n || (reg_wr && reg_addr == gled_pkg::REG_CFG)) begin
            led_q <= rst_n ? reg_wdata[gled_pkg::CFG_LED_LSB +: 3] : 3'h0;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    unmapped_rd_a: assert property (reg_rd && (reg_addr > 4'h8 || reg_addr[1:0] != 2'h0)
        |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
    led_od_a: assert property ((led_q & led_d & gpio_oe & gpio_out) == 3'h0)
        else $error("led pin driven high");
    speed_off_a: assert property ((led_q[0] && slow) [*3] |-> !gpio_oe[0])
        else $error("speed led not off at 10M");
    speed_on_a: assert property ((led_q[0] && !slow) [*3] |-> gpio_oe[0] && !gpio_out[0])
        else $error("speed led not on");
    dup_on_a: assert property ((led_q[2] && fdx) [*3] |-> gpio_oe[2] && !gpio_out[2])
        else $error("duplex led not on");
    dup_off_a: assert property ((led_q[2] && !fdx) [*3] |-> !gpio_oe[2])
        else $error("duplex led not off");
    link_down_a: assert property ((led_q[1] && !link_up) [*3] |-> !gpio_oe[1])
        else $error("link led on without link");
endmodule
bind gled_top gled_props #(.FLASH_CYCLES(FLASH_CYCLES)) props_i (.mclk(mclk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .link_up(link_up), .link_10m(link_10m),
    .autoneg_busy(autoneg_busy), .full_duplex(full_duplex), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe));

// File: verification/gpio_led_status_indicators_bench.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module gpio_led_status_indicators_bench;
    localparam int FC = 10;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, rd_q = 1'b0, link_up = 1'b0, link_10m = 1'b0;
    logic autoneg_busy = 1'b0, full_duplex = 1'b0, tx_active = 1'b0, rx_active = 1'b0;
    logic [31:0] reg_rdata, exp_v;
    logic [2:0] gpio_in, gpio_out, gpio_oe, ext_val = 3'h0, ext_en = 3'h0;
    logic [31:0] exp_q[$];
    int err_total = 0, num_checks = 0, seed = 32'h82538057, n;
    always #20 mclk = ~mclk;
    gled_top #(.FLASH_CYCLES(FC)) DUT (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .link_up(link_up), .link_10m(link_10m), .autoneg_busy(autoneg_busy),
        .full_duplex(full_duplex), .tx_active(tx_active), .rx_active(rx_active),
        .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe));
    gled_pads pads (.gpio_out(gpio_out), .gpio_oe(gpio_oe), .ext_val(ext_val),
        .ext_en(ext_en), .gpio_in(gpio_in));
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
    endtask
    task automatic settle();
        repeat (3) @(posedge mclk);
    endtask
    // bounded so a stuck led cannot hang the run
    task automatic span(input logic v, output int c);
        c = 0;
        while (gpio_oe[1] === v && c < 100) begin
            @(posedge mclk);
            c++;
        end
    endtask
    always @(posedge mclk) begin
        rd_q <= reg_rd;
        if (rd_q) begin
            exp_v = exp_q.pop_front();
            `CHK(reg_rdata, exp_v)
        end
    end
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        err_total++;
        summarize();
    end
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        wr(4'h0, 32'h7);
        wr(4'h4, 32'h5);
        settle();
        `CHK({gpio_oe, gpio_out}, 6'h3D)
        rd(4'h8, 32'h5);
        wr(4'h0, 32'h77);
        settle();
        `CHK(gpio_oe, 3'h2)
        rd(4'h8, 32'h5);
        rd(4'h0, 32'h77);
        rd(4'h4, 32'h5);
        wr(4'h0, 32'h0);
        ext_en <= 3'h7;
        for (int i = 0; i < 4; i++) begin
            ext_val <= 3'($random(seed));
            settle();
            rd(4'h8, {29'h0, ext_val});
        end
        wr(4'hC, 32'hFFFFFFFF);
        rd(4'hC, 32'h0);
        settle();
        `CHK(gpio_oe, 3'h0)
        ext_en <= 3'h0;
        // push-pull config under the led role: pins must still be open drain
        wr(4'h0, 32'h707);
        rd(4'h0, 32'h707);
        link_up <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            {link_10m, autoneg_busy, full_duplex} <= 3'(i);
            settle();
            `CHK(gpio_oe, {i[0], 1'b1, ~(i[2] & ~i[1])})
            `CHK(gpio_out, 3'h0)
        end
        tx_active <= 1'b1;
        @(posedge mclk);
        tx_active <= 1'b0;
        span(1'b1, n);
        rx_active <= 1'b1;
        span(1'b0, n);
        `CHK(n, FC)
        span(1'b1, n);
        `CHK(n, FC)
        // drop the link early in the off pulse; relink before it could end
        link_up <= 1'b0;
        rx_active <= 1'b0;
        autoneg_busy <= 1'b0;
        settle();
        `CHK(gpio_oe, 3'h1)
        link_up <= 1'b1;
        settle();
        `CHK(gpio_oe, 3'h6)
        link_up <= 1'b0;
        settle();
        span(1'b0, n);
        `CHK(n, 100)
        link_up <= 1'b1;
        settle();
        `CHK(gpio_oe[1], 1'b1)
        summarize();
    end
endmodule
